// ---- dpcr_pkg.sv ----
// Shared constants, types and field layouts for the demod profile and coefficient store.
package dpcr_pkg;

  // ==========================================================================
  // Register indices (low five address bits; upper bits are ignored)
  // ==========================================================================
  localparam logic [4:0] IDX_CTRL  = 5'h00;
  localparam logic [4:0] IDX_SERZ  = 5'h03;
  localparam logic [4:0] IDX_CPTR  = 5'h06;
  localparam logic [4:0] IDX_CDATA = 5'h07;
  localparam logic [4:0] IDX_PPTR  = 5'h08;
  localparam logic [4:0] IDX_PDATA = 5'h09;
  localparam logic [4:0] IDX_PSEL  = 5'h0E;
  localparam logic [4:0] IDX_TEST  = 5'h1D;
  localparam logic [4:0] IDX_MCTL  = 5'h1F;

  // ==========================================================================
  // Field positions, values and reset values
  // ==========================================================================
  localparam int          CTRL_RDOUT_BIT = 1;
  localparam int          CTRL_TRIG_BIT  = 2;
  localparam int          PSEL_LSB       = 11;
  localparam int          MCTL_EN_BIT    = 15;
  localparam int          MCTL_ADDR_LSB  = 7;
  localparam int          TEST_IMP_BIT   = 3;
  localparam int          SERZ_LSB       = 13;
  localparam logic [1:0]  SERZ_14X       = 2'h2;
  localparam logic [15:0] RST_REG16      = 16'h0000;
  localparam logic [7:0]  RST_PTR8       = 8'h00;
  localparam logic [4:0]  RST_PTR5       = 5'h00;

  // ==========================================================================
  // Frame lengths, sizes and test pattern
  // ==========================================================================
  localparam logic [7:0]  ADDR_BITS  = 8'h08;
  localparam logic [6:0]  LEN_REG    = 7'h10;
  localparam logic [6:0]  LEN_PROF   = 7'h40;
  localparam logic [6:0]  LEN_COEF   = 7'h70;
  localparam logic [15:0] IMPULSE_VAL = 16'h4000;
  localparam logic [15:0] ZERO_VAL    = 16'h0000;
  localparam int          PROF_DEPTH = 32;
  localparam int          COEF_DEPTH = 256;
  localparam int          COEF_W     = 14;
  localparam int          BLK_W      = 112;
  localparam int          MAX_DEC    = 32;
  localparam logic [5:0]  DEC_MAX    = 6'h20;
  localparam logic [5:0]  DEC_MIN    = 6'h01;
  localparam logic [2:0]  BLK_SHIFT  = 3'h3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    DPCR_IDLE = 2'b00,
    DPCR_PROF = 2'b01,
    DPCR_COPY = 2'b11
  } dpcr_fsm_e;

  typedef struct packed {
    logic [27:0] rsv_hi;
    logic [7:0]  cptr;
    logic [5:0]  dec;
    logic [15:0] freq;
    logic        rsv5;
    logic [2:0]  gain;
    logic [1:0]  ign;
  } dpcr_prof_s;

  typedef struct packed {
    logic sen_n;
    logic sclk;
    logic sdata;
    logic digital_section_select_pin;
  } dpcr_pin_s;

  typedef struct packed {
    logic [7:0]       addr;
    logic             addr_valid;
    logic             bit_tick;
    logic             wr;
    logic [BLK_W-1:0] data;
  } dpcr_frame_s;

endpackage

// ---- dpcr_serial.sv ----
// Serial configuration port deframer: address byte, then a data word MSB first.
`timescale 1ns/1ps
module dpcr_serial (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire dpcr_pkg::dpcr_pin_s pins,
  output dpcr_pkg::dpcr_frame_s    frame
);
  import dpcr_pkg::*;

  typedef struct packed {
    logic        sclk_q;
    logic [7:0]  cnt;
    logic [6:0]  len;
    dpcr_frame_s fr;
  } dpcr_ser_s;

  dpcr_ser_s  st_r;
  dpcr_ser_s  st_nxt;
  logic       rise;
  logic [7:0] addr_sh;
  logic [7:0] end_cnt;

  // ==========================================================================
  // Frame decode
  // ==========================================================================
  // Pins are sampled on mclk, so sclk must be well below mclk/2.
  always_comb begin
    st_nxt               = st_r;
    st_nxt.sclk_q        = pins.sclk;
    st_nxt.fr.addr_valid = 1'b0;
    st_nxt.fr.bit_tick   = 1'b0;
    st_nxt.fr.wr         = 1'b0;
    rise                 = pins.sclk & ~st_r.sclk_q;
    addr_sh              = {st_r.fr.addr[6:0], pins.sdata};
    end_cnt              = {1'b0, st_r.len} + ADDR_BITS;
    if (pins.sen_n) begin
      st_nxt.cnt = '0;
    end else if (rise && st_r.cnt < ADDR_BITS) begin
      st_nxt.fr.addr = addr_sh;
      st_nxt.cnt     = st_r.cnt + 8'h01;
      if (st_r.cnt == ADDR_BITS - 8'h01) begin
        st_nxt.fr.addr_valid = 1'b1;
        st_nxt.fr.data       = '0;
        // Wide data ports take their full word; all others take 16 bits.
        case (addr_sh[4:0])
          IDX_CDATA: st_nxt.len = LEN_COEF;
          IDX_PDATA: st_nxt.len = LEN_PROF;
          default:   st_nxt.len = LEN_REG;
        endcase
      end
    end else if (rise && st_r.cnt < end_cnt) begin
      st_nxt.fr.data     = {st_r.fr.data[BLK_W-2:0], pins.sdata};
      st_nxt.fr.bit_tick = 1'b1;
      st_nxt.cnt         = st_r.cnt + 8'h01;
      if (st_r.cnt == end_cnt - 8'h01) begin
        st_nxt.fr.wr = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign frame = st_r.fr;

endmodule

// ---- dpcr_impulse.sv ----
// Filter input source: converter samples, or one impulse then 16*M zeros in test mode.
`timescale 1ns/1ps
module dpcr_impulse #(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         impulse_test_enable,
  input  wire logic [5:0]   dec_m,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_sample,
  output logic              out_valid,
  output logic [W-1:0]      out_sample
);
  import dpcr_pkg::*;

  typedef struct packed {
    logic [9:0]   cnt;
    logic         vld;
    logic [W-1:0] smp;
  } dpcr_imp_s;

  dpcr_imp_s  st_r;
  dpcr_imp_s  st_nxt;
  logic [9:0] period_end;

  // ==========================================================================
  // Sample source
  // ==========================================================================
  // The counter paces itself on the converter strobe, so the pattern keeps the
  // sample rate that the filter expects.
  always_comb begin
    st_nxt     = st_r;
    st_nxt.vld = in_valid;
    period_end = {dec_m, 4'h0};
    if (in_valid) begin
      if (impulse_test_enable) begin
        st_nxt.smp = (st_r.cnt == '0) ? W'(IMPULSE_VAL) : W'(ZERO_VAL);
        st_nxt.cnt = (st_r.cnt >= period_end) ? '0 : st_r.cnt + 10'h001;
      end else begin
        st_nxt.smp = in_sample;
        st_nxt.cnt = '0;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_valid  = st_r.vld;
  assign out_sample = st_r.smp;

endmodule

// ---- dpcr_top.sv ----
// Profile RAM, coefficient RAM and trigger-loaded filter configuration of the demodulator.
// Function
// - Test enable feeds filter one 0x4000 impulse then 16*M zero samples.
// - Reset leaves profile and coefficient RAM contents untouched.
// - New RAM and selector contents take effect only after a trigger.
// - Profile RAM is 32 by 64 bits, addressed by a 5-bit pointer.
// - Profile holds block pointer 35:28, decimation 27:22, frequency 21:6.
// - Profile bits 4:2 are gain; reserved bits written zero; 1:0 ignored.
// - Coefficients fetched from block pointer times 8 for M blocks.
// - Active profile is the entry named by the 5-bit selector field.
// - Manual start enable substitutes the manual 8-bit start address.
// - Coefficient RAM is 256 by 112 bits, addressed by 8-bit pointer.
// - Block written MSB first; coefficient k sits in bits 14k+13:14k.
// - Filter has 16*M symmetric taps from 8*M stored coefficients.
// - Slot i of block j holds coefficient M*(1+i)-(1+j).
// - In readout, only control register writes store; register contents shift out serially.
// - Serialization field value 10 switches the demodulator to 14x.
`timescale 1ns/1ps
module dpcr_top (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire dpcr_pkg::dpcr_pin_s cfg_pins,
  input  wire logic                sync_in,
  input  wire logic                adc_valid,
  input  wire logic [13:0]         adc_sample,
  input  wire logic [9:0]          tap_idx,
  output logic                     serial_data_output_pin,
  output logic                     filt_valid,
  output logic [15:0]              filt_sample,
  output logic [13:0]              tap_coef,
  output logic [5:0]               dec_factor,
  output logic [15:0]              down_freq,
  output logic [2:0]               gain_comp,
  output logic [7:0]               coeff_start,
  output logic                     cfg_busy,
  output logic                     ser_14x
);
  import dpcr_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0]  cptr;
    logic [4:0]  pptr;
    logic [15:0] psel;
    logic [15:0] mctl;
    logic [15:0] test;
    logic [15:0] serz;
    logic        rd_en;
    logic [15:0] rd_sh;
    logic        sdo;
    logic        sync_q;
    logic        pend;
    dpcr_fsm_e   fsm;
    logic        busy;
    logic [4:0]  sel_act;
    dpcr_prof_s  act;
    logic [7:0]  start;
    logic [4:0]  j;
    logic [4:0]  jlast;
    logic [13:0] tap_c;
    logic        ser14;
  } dpcr_state_s;

  dpcr_state_s      st_r;
  dpcr_state_s      st_nxt;
  dpcr_frame_s      fr;
  logic [63:0]      prof_ram [PROF_DEPTH];
  logic [BLK_W-1:0] coef_ram [COEF_DEPTH];
  logic [BLK_W-1:0] work_ram [MAX_DEC];

  logic [4:0]       idx;
  logic             dig_low;
  logic             wr_ok;
  logic             sync_rise;
  logic             man_trig;
  logic             trig;
  logic             prof_we;
  logic             coef_we;
  logic             copy_we;
  logic [7:0]       copy_addr;
  dpcr_prof_s       prof_rd;
  logic [7:0]       prof_start;
  logic [7:0]       man_addr;
  logic             man_en;
  logic [15:0]      rd_val;
  logic [5:0]       m_act;
  logic [5:0]       m_new;
  logic [9:0]       m10;
  logic [9:0]       nn;
  logic [2:0]       tap_i;
  logic [4:0]       tap_j;
  logic [6:0]       tap_off;
  logic [BLK_W-1:0] tap_blk;

  // Decimation factors outside 1..32 are clamped so the copy never overruns.
  function automatic logic [5:0] m_clamp(input logic [5:0] d);
    logic [5:0] r;
    r = d;
    if (d < DEC_MIN) begin
      r = DEC_MIN;
    end else if (d > DEC_MAX) begin
      r = DEC_MAX;
    end
    return r;
  endfunction

  // ==========================================================================
  // Serial port and sample source
  // ==========================================================================
  dpcr_serial u_serial (
    .mclk  (mclk),
    .nrst  (nrst),
    .pins  (cfg_pins),
    .frame (fr)
  );

  dpcr_impulse #(
    .W (16)
  ) u_impulse (
    .mclk                (mclk),
    .nrst                (nrst),
    .impulse_test_enable (st_r.test[TEST_IMP_BIT]),
    .dec_m               (m_act),
    .in_valid            (adc_valid),
    .in_sample           ({{2{adc_sample[13]}}, adc_sample}),
    .out_valid           (filt_valid),
    .out_sample          (filt_sample)
  );

  // ==========================================================================
  // Access decode
  // ==========================================================================
  // Writes with the section pin high belong to the converter side and are
  // dropped here; the control register stays writable so readout can end.
  assign idx        = fr.addr[4:0];
  assign dig_low    = ~cfg_pins.digital_section_select_pin;
  assign wr_ok      = fr.wr & dig_low & (~st_r.rd_en | (idx == IDX_CTRL));
  assign sync_rise  = sync_in & ~st_r.sync_q;
  assign man_trig   = wr_ok & (idx == IDX_CTRL) & fr.data[CTRL_TRIG_BIT];
  assign trig       = sync_rise | man_trig;
  assign prof_we    = wr_ok & (idx == IDX_PDATA);
  assign coef_we    = wr_ok & (idx == IDX_CDATA);
  assign copy_we    = (st_r.fsm == DPCR_COPY);
  assign copy_addr  = st_r.start + {3'h0, st_r.j};
  assign prof_rd    = prof_ram[st_r.sel_act];
  assign prof_start = prof_rd.cptr << BLK_SHIFT;
  assign man_addr   = st_r.mctl[MCTL_ADDR_LSB +: 8];
  assign man_en     = st_r.mctl[MCTL_EN_BIT];
  assign m_act      = m_clamp(st_r.act.dec);
  assign m_new      = m_clamp(prof_rd.dec);

  // Readback value; the wide data ports are write only and read as zero.
  always_comb begin
    rd_val = RST_REG16;
    case (idx)
      IDX_CTRL: rd_val = {13'h0000, 2'h0, st_r.rd_en} << CTRL_RDOUT_BIT;
      IDX_SERZ: rd_val = st_r.serz;
      IDX_CPTR: rd_val = {8'h00, st_r.cptr};
      IDX_PPTR: rd_val = {11'h000, st_r.pptr};
      IDX_PSEL: rd_val = st_r.psel;
      IDX_TEST: rd_val = st_r.test;
      IDX_MCTL: rd_val = st_r.mctl;
      default:  rd_val = RST_REG16;
    endcase
  end

  // ==========================================================================
  // Tap lookup
  // ==========================================================================
  // Mirror the upper half of the taps onto the stored half, then map tap n to
  // slot i = n / M of block j = M - 1 - n % M. The divider is combinational and
  // sets the tap lookup timing; only one tap is answered per cycle.
  always_comb begin
    m10     = {4'h0, m_act};
    nn      = (tap_idx >= {1'b0, m_act, 3'h0}) ?
              ({m_act, 4'h0} - 10'h001 - tap_idx) : tap_idx;
    tap_i   = 3'(nn / m10);
    tap_j   = 5'(m10 - 10'h001 - (nn % m10));
    tap_off = 7'(tap_i) * 7'(COEF_W);
    tap_blk = work_ram[tap_j];
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_nxt        = st_r;
    st_nxt.sync_q = sync_in;
    // Register writes; coefficient pointer reads show the auto-increment.
    if (wr_ok) begin
      case (idx)
        IDX_CTRL:  st_nxt.rd_en = fr.data[CTRL_RDOUT_BIT];
        IDX_SERZ:  st_nxt.serz  = fr.data[15:0];
        IDX_CPTR:  st_nxt.cptr  = fr.data[7:0];
        IDX_CDATA: st_nxt.cptr  = st_r.cptr + 8'h01;
        IDX_PPTR:  st_nxt.pptr  = fr.data[4:0];
        IDX_PSEL:  st_nxt.psel  = fr.data[15:0];
        IDX_TEST:  st_nxt.test  = fr.data[15:0];
        IDX_MCTL:  st_nxt.mctl  = fr.data[15:0];
        default:   st_nxt.rd_en = st_r.rd_en;
      endcase
    end
    // Readout: load at the end of the address byte, shift per data bit.
    if (fr.addr_valid && st_r.rd_en && dig_low) begin
      st_nxt.rd_sh = rd_val;
    end else if (fr.bit_tick && st_r.rd_en) begin
      st_nxt.sdo   = st_r.rd_sh[15];
      st_nxt.rd_sh = {st_r.rd_sh[14:0], 1'b0};
    end
    // A trigger during a load is held; in idle the hold clears even when a new one arrives.
    st_nxt.pend = (st_r.fsm == DPCR_IDLE) ? 1'b0 : (st_r.pend | trig);
    unique case (st_r.fsm)
      DPCR_IDLE: begin
        if (trig || st_r.pend) begin
          st_nxt.sel_act = st_r.psel[PSEL_LSB +: 5];
          st_nxt.fsm     = DPCR_PROF;
          st_nxt.busy    = 1'b1;
        end
      end
      DPCR_PROF: begin
        st_nxt.act   = prof_rd;
        st_nxt.start = man_en ? man_addr : prof_start;
        st_nxt.j     = '0;
        st_nxt.jlast = 5'(m_new - DEC_MIN);
        st_nxt.fsm   = DPCR_COPY;
      end
      DPCR_COPY: begin
        st_nxt.j = st_r.j + 5'h01;
        if (st_r.j == st_r.jlast) begin
          st_nxt.fsm  = DPCR_IDLE;
          st_nxt.busy = 1'b0;
        end
      end
    endcase
    st_nxt.tap_c = tap_blk[tap_off +: COEF_W];
    st_nxt.ser14 = (st_r.serz[SERZ_LSB +: 2] == SERZ_14X);
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r       <= '0;
      st_r.fsm   <= DPCR_IDLE;
      st_r.cptr  <= RST_PTR8;
      st_r.pptr  <= RST_PTR5;
      st_r.serz  <= RST_REG16;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Memories
  // ==========================================================================
  // No reset here on purpose: contents survive a device reset, and the
  // working copy is refreshed only by a trigger-started load.
  always_ff @(posedge mclk) begin
    if (prof_we) begin
      prof_ram[st_r.pptr] <= fr.data[63:0];
    end
    if (coef_we) begin
      coef_ram[st_r.cptr] <= fr.data;
    end
    if (copy_we) begin
      work_ram[st_r.j] <= coef_ram[copy_addr];
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign serial_data_output_pin = st_r.sdo;
  assign tap_coef               = st_r.tap_c;
  assign dec_factor             = st_r.act.dec;
  assign down_freq              = st_r.act.freq;
  assign gain_comp              = st_r.act.gain;
  assign coeff_start            = st_r.start;
  assign cfg_busy               = st_r.busy;
  assign ser_14x                = st_r.ser14;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic       ser_wr14;
  logic       rd_msb;
  assign ser_wr14 = wr_ok & (idx == IDX_SERZ) & (fr.data[SERZ_LSB +: 2] == SERZ_14X);
  assign rd_msb   = st_r.rd_sh[15];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_trig_starts_load: assert property ((st_r.fsm == DPCR_IDLE) && trig |=>
    (st_r.fsm == DPCR_PROF) ##1 (st_r.fsm == DPCR_COPY))
    else $error("trigger did not start a profile load");
  a_no_trig_no_load: assert property ((st_r.fsm == DPCR_IDLE) && !trig && !st_r.pend
    |=> $stable(st_r.act) && (st_r.fsm == DPCR_IDLE))
    else $error("profile changed without a trigger");
  a_busy_trig_held: assert property ((st_r.fsm != DPCR_IDLE) && trig |=> st_r.pend)
    else $error("trigger during load was lost");
  a_profile_select: assert property ((st_r.fsm == DPCR_PROF) |=>
    st_r.act == $past(prof_rd))
    else $error("active profile not taken from selected entry");
  a_manual_start: assert property ((st_r.fsm == DPCR_PROF) && man_en |=>
    st_r.start == $past(man_addr))
    else $error("manual start address not used");
  a_profile_start: assert property ((st_r.fsm == DPCR_PROF) && !man_en |=>
    st_r.start == $past(prof_start))
    else $error("start address is not pointer times eight");
  a_copy_length: assert property ((st_r.fsm == DPCR_COPY) && (st_r.j == st_r.jlast)
    |=> (st_r.fsm == DPCR_IDLE) && !st_r.busy)
    else $error("coefficient copy length wrong");
  a_cptr_increment: assert property (coef_we |=> st_r.cptr == $past(st_r.cptr) + 8'h01)
    else $error("coefficient pointer did not advance");
  a_readout_blocks: assert property (st_r.rd_en && fr.wr && (idx == IDX_PSEL)
    |=> $stable(st_r.psel))
    else $error("register changed during readout");
  a_readout_shift: assert property (st_r.rd_en && fr.bit_tick && !fr.addr_valid
    |=> serial_data_output_pin == $past(rd_msb))
    else $error("readout bit not shifted out");
  a_serz_14x: assert property (ser_wr14 |-> ##2 ser_14x)
    else $error("14x serialization not selected");

  c_manual_trigger: cover property (man_trig ##[1:40] (st_r.fsm == DPCR_COPY));
  c_load_done: cover property ((st_r.fsm == DPCR_COPY) ##1 (st_r.fsm == DPCR_IDLE));
  c_readout_bit: cover property (st_r.rd_en && fr.bit_tick);
  c_impulse_out: cover property (filt_valid && (filt_sample == IMPULSE_VAL));

endmodule

// ---- dpcr_host.sv ----
// Host controller model that drives the serial configuration pins.
`timescale 1ns/1ps
module dpcr_host (
  input  wire logic           mclk,
  input  wire logic           sdo,
  output dpcr_pkg::dpcr_pin_s pins
);
  import dpcr_pkg::*;
  logic [111:0] rd;
  // ==================
  // Frame driver
  // ==================
  // Idle pins: frame off and sclk low, so a reset release never sees a rising sclk.
  initial pins = '{1'b1, 1'b0, 1'b0, 1'b0};
  // One frame, address then data MSB first; each sclk phase lasts two cycles.
  task automatic xfer(input logic dsel, input logic [7:0] a,
                      input logic [111:0] d, input int n);
    @(negedge mclk) pins <= '{1'b0, 1'b0, pins.sdata, dsel};
    for (int k = 0; k < n + 8; k++) begin
      @(negedge mclk) pins.sdata <= (k < 8) ? a[7-k] : d[n+7-k];
      @(negedge mclk) pins.sclk <= 1'b1;
      repeat (2) @(negedge mclk);
      rd <= {rd[110:0], sdo};
      pins.sclk <= 1'b0;
    end
    @(negedge mclk) pins.sen_n <= 1'b1;
    // The released data line flips so that a stale bit is never mistaken for data.
    pins.sdata <= ~pins.sdata;
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the demod profile and coefficient store.
`timescale 1ns/1ps
module tb_top;
  import dpcr_pkg::*;
  logic        mclk, nrst, sync_in, adc_valid, sdo, fv, busy, s14;
  logic [9:0]  tap_idx;
  logic [15:0] fs, frq;
  logic [13:0] tc, adc;
  logic [5:0]  dec;
  logic [2:0]  gn;
  logic [7:0]  cst;
  dpcr_pin_s   pins;
  int          miscompares, tests_run, cyc, m;
  dpcr_host i_dpcr_host (.mclk(mclk), .sdo(sdo), .pins(pins));
  dpcr_top i_dpcr_top (.mclk(mclk), .nrst(nrst), .cfg_pins(pins), .sync_in(sync_in),
    .adc_valid(adc_valid), .adc_sample(adc), .tap_idx(tap_idx),
    .serial_data_output_pin(sdo), .filt_valid(fv), .filt_sample(fs), .tap_coef(tc),
    .dec_factor(dec), .down_freq(frq), .gain_comp(gn), .coeff_start(cst),
    .cfg_busy(busy), .ser_14x(s14));
  // ==================
  // Helpers
  // ==================
  // The clock never stops, so the converter clock runs while the RAMs load.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // A hang is cut short well beyond the few thousand cycles the tests need.
  always @(negedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_dpcr_host.xfer(1'b0, a, {96'h0, d}, 16);
  endtask
  // Waits for a trigger-started load to finish, bounded.
  task automatic settle;
    repeat (2) @(negedge mclk);
    for (int k = 0; k < 64 && busy !== 1'b0; k++) @(negedge mclk);
    chk("busy", 16'(busy), 16'h0000);
  endtask
  function automatic logic [111:0] blk(input int b);
    for (int s = 0; s < 8; s++) blk[14*s +: 14] = 14'(b * 8 + s + 1);
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==================
  // Tests
  // ==================
  initial begin
    {nrst, sync_in, adc_valid, tap_idx} = '0;
    // A negative, non-zero sample, so test zeros differ from pass-through data.
    adc = 14'h3123;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    // RAMs first, pointer before data; profile 3 points at block 0x10 with M=2.
    wr(8'h08, 16'h0003);
    i_dpcr_host.xfer(1'b0, 8'h09, {76'h0, 8'h02, 6'h02, 16'h1234, 4'h5, 2'h3}, 64);
    wr(8'h06, 16'h0010);
    for (int b = 0; b < 2; b++) i_dpcr_host.xfer(1'b0, 8'h07, blk(b), 112);
    wr(8'h0E, 16'h1800);
    chk("dec before trigger", 16'(dec), 16'h0000);
    wr(8'h00, 16'h0004);
    settle();
    chk("dec", 16'(dec), 16'h0002);
    chk("freq", frq, 16'h1234);
    chk("gain", 16'(gn), 16'h0005);
    chk("start", 16'(cst), 16'h0010);
    for (int n = 0; n < 32; n++) begin
      m = (n < 16) ? n : 31 - n;
      tap_idx = 10'(n);
      @(negedge mclk);
      chk("tap", 16'(tc), 16'((1 - m % 2) * 8 + m / 2 + 1));
    end
    $display("done: profile and taps");
    wr(8'h1D, 16'h0008);
    for (int k = 0; k < 34; k++) begin
      @(negedge mclk) adc_valid = 1'b1;
      @(negedge mclk) adc_valid = 1'b0;
      chk("filt", fv ? fs : 16'hFFFF, (k % 33 == 0) ? IMPULSE_VAL : ZERO_VAL);
    end
    wr(8'h1D, 16'h0000);
    @(negedge mclk) adc_valid = 1'b1;
    @(negedge mclk) adc_valid = 1'b0;
    chk("filt pass", fs, 16'hF123);
    $display("done: impulse");
    wr(8'h1F, 16'h9000);
    chk("start before sync", 16'(cst), 16'h0010);
    @(negedge mclk) sync_in = 1'b1;
    @(negedge mclk) chk("busy", 16'(busy), 16'h0001);
    settle();
    sync_in = 1'b0;
    chk("manual start", 16'(cst), 16'h0020);
    wr(8'hC3, 16'h4000);
    repeat (3) @(negedge mclk);
    chk("ser14", 16'(s14), 16'h0001);
    // Converter-side field set to 01 with the pin high; the demod side must not change.
    i_dpcr_host.xfer(1'b1, 8'h03, 112'h2000, 16);
    repeat (2) @(negedge mclk);
    chk("ser14 kept", 16'(s14), 16'h0001);
    $display("done: manual start and serialization");
    i_dpcr_host.xfer(1'b0, 8'h00, 112'h2, 16);
    i_dpcr_host.xfer(1'b1, 8'h00, 112'h2, 16);
    wr(8'h0E, 16'h0000);
    chk("readout", i_dpcr_host.rd[15:0], 16'h1800);
    i_dpcr_host.xfer(1'b1, 8'h00, 112'h0, 16);
    wr(8'h00, 16'h0000);
    wr(8'h00, 16'h0004);
    settle();
    chk("dec after readout", 16'(dec), 16'h0002);
    $display("done: readout");
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    wr(8'h0E, 16'h1800);
    wr(8'h00, 16'h0004);
    settle();
    chk("dec after reset", 16'(dec), 16'h0002);
    chk("start after reset", 16'(cst), 16'h0010);
    @(negedge mclk);
    chk("tap after reset", 16'(tc), 16'h0009);
    $display("done: reset keeps RAM");
    end_of_test();
  end
endmodule
